//--- sfp_ctrl_pkg.sv
/*
  Shared constants, types and state encodings for the module control and
  status block. Assumes a 10 MHz system clock and a free-running link clock
  that oversamples the two-wire serial pins.
*/
`default_nettype none

package sfp_ctrl_pkg;

  // ---------------------------------------------------------------
  // clock rate and documented times
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int CYC_PER_US = SYS_CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS = SYS_CLK_HZ / 1_000;
  localparam int T_INIT_MS = 300;   // longest: init incl. fault clear
  localparam int T_DATA_MS = 1000;  // longest: analog data ready
  localparam int T_SERIAL_MS = 300; // longest: serial bus ready
  localparam int T_WRITE_MS = 10;   // longest: internal write cycle
  localparam int T_RESET_US = 10;   // least: disable hold to clear fault
  localparam int INIT_CYC = T_INIT_MS * CYC_PER_MS;
  localparam int DATA_CYC = T_DATA_MS * CYC_PER_MS;
  localparam int SERIAL_CYC = T_SERIAL_MS * CYC_PER_MS;
  localparam int WRITE_CYC = T_WRITE_MS * CYC_PER_MS;
  localparam int RESET_CYC = (T_RESET_US * SYS_CLK_HZ + 999_999) / 1_000_000;
  localparam int CNT_W = 24;

  // ---------------------------------------------------------------
  // serial addressing and the control/status byte
  // ---------------------------------------------------------------
  localparam logic [6:0] DEV_ID_PAGE = 7'h50;   // page at A0h
  localparam logic [6:0] DEV_DIAG_PAGE = 7'h51; // page at A2h
  localparam logic [7:0] CONTROL_STATUS_BYTE = 8'h6E;
  localparam logic [7:0] EMPTY_BYTE = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int BIT_HW_OFF = 7;
  localparam int BIT_SOFT_OFF = 6;
  localparam int BIT_HW_RATE = 4;
  localparam int BIT_SOFT_RATE = 3;
  localparam int BIT_FAULT = 2;
  localparam int BIT_LOST = 1;
  localparam int BIT_READY = 0;
  localparam logic RAIL_TX = 1'b1; // monitor mux code for transmit rail

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {L_INIT, L_ON, L_OFF, L_FAULT} laser_state_t;
  typedef enum logic [3:0] {
    S_IDLE, S_DEVADDR, S_ACKDEV, S_WORD, S_ACKWORD, S_WRDATA, S_ACKDATA,
    S_RDDATA, S_RDACK
  } bus_state_t;
  typedef struct packed {
    logic ready;
    logic busy;
    logic [7:0] status;
  } link_status_t;
  typedef struct packed {
    logic txOff;
    logic rateSel;
    logic sigLost;
    logic laserFault;
  } pin_in_t;

endpackage

`default_nettype wire

//--- sfp_module_control_status.sv
/*
  Control and status logic of a pluggable optical transceiver: hardware
  disable, rate choice, fault and signal-lost pins, and the control/status
  byte of the diagnostic page reached over the two-wire serial bus.
  Assumes pins arrive asynchronously, the link clock runs free and
  oversamples the serial pins, and the analog laser/receiver front end
  reports fault and signal loss as levels.
*/
// Contract
// - rising hardware disable turns the optical output off.
// - falling hardware disable restores modulated optical output.
// - after power-on or disable release, initialise and clear fault first.
// - disable held high long enough resets the latched fault shutdown.
// - signal-lost output goes active after optical signal loss.
// - signal-lost output goes inactive after a valid signal returns.
// - either edge of the rate input reconfigures the receiver rate.
// - writing one to the soft disable bit turns the transmitter off.
// - clearing the soft disable bit re-enables modulated output.
// - soft fault status bit sets after a transmitter fault.
// - soft signal-lost bit follows loss and return of signal.
// - writing the soft rate bit switches receiver bandwidth after stop.
// - data-ready bit asserts once analog monitoring is working.
// - host waits for serial bus readiness after power-on.
// - internal write completes after stop; host waits for it.
// - supply monitor reads the transmit supply rail.
// - soft disable and soft status bits take effect within 100 ms.
`timescale 1ns/1ns
`default_nettype none

module sfp_module_control_status
  import sfp_ctrl_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int DATA_CYCLES = DATA_CYC,
  parameter int SERIAL_CYCLES = SERIAL_CYC,
  parameter int WRITE_CYCLES = WRITE_CYC
)
(
  input wire logic sys_clk, // system clock, 10 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic linkClk, // serial oversampling clock
  input wire logic txOffPin, // hardware transmit-off pin
  input wire logic rateSelPin, // hardware bandwidth-choice pin
  input wire logic sigLostIn, // receiver detector: signal lost
  input wire logic laserFaultIn, // laser driver: fault seen
  input wire logic sclPin, // serial clock from host
  input wire logic sdaIn, // serial data wire level
  output logic sdaOut, // serial data drive value
  output logic sdaOe, // serial data drive enable
  output logic laserEnable, // modulated optical output on
  output logic txFaultPin, // latched transmit fault pin
  output logic receiveSignalLost, // signal-lost pin
  output logic rxRateHigh, // receiver bandwidth choice
  output logic transmitSupplyRailSel // monitor input select
);

  // ---------------------------------------------------------------
  // shared decode
  // ---------------------------------------------------------------
  // addresses the control/status byte of the diagnostic page
  function automatic logic isCtrlByte(input logic diag, input logic [7:0] ofs);
    isCtrlByte = diag && (ofs == CONTROL_STATUS_BYTE);
  endfunction

  // value returned for a read; other bytes are outside this block
  function automatic logic [7:0] readByte(input logic diag, input logic [7:0] ofs,
                                          input logic [7:0] stat);
    readByte = isCtrlByte(diag, ofs) ? stat : EMPTY_BYTE;
  endfunction

  // ---------------------------------------------------------------
  // system domain
  // ---------------------------------------------------------------
  pin_in_t pinSync1_r;
  pin_in_t pinSync2_r;
  logic reqSync1_r;
  logic reqSync2_r;
  logic reqSeen_r, reqSeen_nxt;
  laser_state_t laser_r, laser_nxt;
  logic [CNT_W-1:0] laserCnt_r, laserCnt_nxt;
  logic [CNT_W-1:0] porCnt_r, porCnt_nxt;
  logic [CNT_W-1:0] wrCnt_r, wrCnt_nxt;
  logic fault_r, fault_nxt;
  logic softOff_r, softOff_nxt;
  logic softRate_r, softRate_nxt;
  logic laserEnable_r, laserEnable_nxt;
  logic receiveSignalLost_r, receiveSignalLost_nxt;
  logic rxRateHigh_r, rxRateHigh_nxt;
  logic railSel_r;
  link_status_t sysStat_r, sysStat_nxt;
  logic [7:0] wrData_r; // written in the link domain by a control-byte data write, held until the next such write
  logic reqTog_r;
  logic disable_c;

  // two-flop synchronisers for pins and the write request toggle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pinSync1_r <= '0;
      pinSync2_r <= '0;
      reqSync1_r <= 1'b0;
      reqSync2_r <= 1'b0;
    end
    else
    begin
      pinSync1_r <= '{txOffPin, rateSelPin, sigLostIn, laserFaultIn};
      pinSync2_r <= pinSync1_r;
      reqSync1_r <= reqTog_r;
      reqSync2_r <= reqSync1_r;
    end
  end

  // laser state, soft controls, power-on timing and status
  always_comb
  begin
    reqSeen_nxt = reqSeen_r;
    softOff_nxt = softOff_r;
    softRate_nxt = softRate_r;
    wrCnt_nxt = wrCnt_r;
    laser_nxt = laser_r;
    laserCnt_nxt = laserCnt_r;
    fault_nxt = fault_r;
    // power-on timer saturates once analog data is ready
    porCnt_nxt = porCnt_r;
    if (porCnt_r < CNT_W'(DATA_CYCLES))
      porCnt_nxt = porCnt_r + CNT_W'(1);
    // a completed write takes only the control bits
    if (reqSync2_r != reqSeen_r)
    begin
      reqSeen_nxt = reqSync2_r;
      softOff_nxt = wrData_r[BIT_SOFT_OFF];
      softRate_nxt = wrData_r[BIT_SOFT_RATE];
      wrCnt_nxt = CNT_W'(WRITE_CYCLES);
    end
    else if (wrCnt_r != '0)
      wrCnt_nxt = wrCnt_r - CNT_W'(1);
    disable_c = pinSync2_r.txOff | softOff_r;
    unique case (laser_r)
      L_INIT:
      begin
        // initialisation with output dark; latched fault already clear
        fault_nxt = 1'b0;
        laserCnt_nxt = laserCnt_r + CNT_W'(1);
        if (disable_c)
        begin
          laser_nxt = L_OFF;
        end
        else if (laserCnt_r >= CNT_W'(INIT_CYCLES - 1))
        begin
          laser_nxt = L_ON;
        end
      end
      L_ON:
      begin
        if (pinSync2_r.laserFault)
        begin
          laser_nxt = L_FAULT;
          fault_nxt = 1'b1;
        end
        else if (disable_c)
        begin
          laser_nxt = L_OFF;
        end
      end
      L_OFF:
      begin
        laserCnt_nxt = '0;
        if (!disable_c)
          laser_nxt = L_INIT;
      end
      L_FAULT:
      begin
        // fault shutdown cleared only by a long enough disable pulse
        if (pinSync2_r.txOff)
        begin
          laserCnt_nxt = laserCnt_r + CNT_W'(1);
          if (laserCnt_r >= CNT_W'(RESET_CYC - 1))
          begin
            laser_nxt = L_OFF;
            fault_nxt = 1'b0;
            laserCnt_nxt = '0;
          end
        end
        else
        begin
          laserCnt_nxt = '0;
        end
      end
    endcase
    laserEnable_nxt = (laser_nxt == L_ON);
    receiveSignalLost_nxt = pinSync2_r.sigLost;
    rxRateHigh_nxt = pinSync2_r.rateSel | softRate_nxt;
    // status view handed to the serial side
    sysStat_nxt.ready = (porCnt_r >= CNT_W'(SERIAL_CYCLES));
    sysStat_nxt.busy = (wrCnt_nxt != '0);
    sysStat_nxt.status = '0;
    sysStat_nxt.status[BIT_HW_OFF] = pinSync2_r.txOff;
    sysStat_nxt.status[BIT_SOFT_OFF] = softOff_nxt;
    sysStat_nxt.status[BIT_HW_RATE] = pinSync2_r.rateSel;
    sysStat_nxt.status[BIT_SOFT_RATE] = softRate_nxt;
    sysStat_nxt.status[BIT_FAULT] = fault_nxt;
    sysStat_nxt.status[BIT_LOST] = pinSync2_r.sigLost;
    sysStat_nxt.status[BIT_READY] = (porCnt_r >= CNT_W'(DATA_CYCLES));
  end

  // registers of the system domain
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reqSeen_r <= 1'b0;
      softOff_r <= 1'b0;
      softRate_r <= 1'b0;
      wrCnt_r <= '0;
      porCnt_r <= '0;
      laser_r <= L_INIT;
      laserCnt_r <= '0;
      fault_r <= 1'b0;
      laserEnable_r <= 1'b0;
      receiveSignalLost_r <= 1'b0;
      rxRateHigh_r <= 1'b0;
      railSel_r <= RAIL_TX;
      sysStat_r <= '0;
    end
    else
    begin
      reqSeen_r <= reqSeen_nxt;
      softOff_r <= softOff_nxt;
      softRate_r <= softRate_nxt;
      wrCnt_r <= wrCnt_nxt;
      porCnt_r <= porCnt_nxt;
      laser_r <= laser_nxt;
      laserCnt_r <= laserCnt_nxt;
      fault_r <= fault_nxt;
      laserEnable_r <= laserEnable_nxt;
      receiveSignalLost_r <= receiveSignalLost_nxt;
      rxRateHigh_r <= rxRateHigh_nxt;
      railSel_r <= RAIL_TX;
      sysStat_r <= sysStat_nxt;
    end
  end

  assign laserEnable = laserEnable_r;
  assign txFaultPin = fault_r;
  assign receiveSignalLost = receiveSignalLost_r;
  assign rxRateHigh = rxRateHigh_r;
  assign transmitSupplyRailSel = railSel_r;

  // ---------------------------------------------------------------
  // link domain: two-wire serial slave
  // ---------------------------------------------------------------
  link_status_t linkSync1_r;
  link_status_t linkSync2_r;
  logic sclSync1_r, sclSync2_r, sclPrev_r;
  logic sdaSync1_r, sdaSync2_r, sdaPrev_r;
  bus_state_t st_r, st_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic diagPage_r, diagPage_nxt;
  logic rdMode_r, rdMode_nxt;
  logic devAck_r, devAck_nxt;
  logic hostAck_r, hostAck_nxt;
  logic wrPend_r, wrPend_nxt;
  logic [7:0] wrData_nxt;
  logic reqTog_nxt;
  logic sdaOe_r, sdaOe_nxt;
  logic sdaOut_r;
  logic sclRise, sclFall, startSeen, stopSeen, match;
  logic [7:0] rdByte;

  // two-flop synchronisers for the pins and the system status
  always_ff @(posedge linkClk or posedge rst)
  begin
    if (rst)
    begin
      linkSync1_r <= '0;
      linkSync2_r <= '0;
      sclSync1_r <= 1'b1;
      sclSync2_r <= 1'b1;
      sclPrev_r <= 1'b1;
      sdaSync1_r <= 1'b1;
      sdaSync2_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end
    else
    begin
      linkSync1_r <= sysStat_r;
      linkSync2_r <= linkSync1_r;
      sclSync1_r <= sclPin;
      sclSync2_r <= sclSync1_r;
      sclPrev_r <= sclSync2_r;
      sdaSync1_r <= sdaIn;
      sdaSync2_r <= sdaSync1_r;
      sdaPrev_r <= sdaSync2_r;
    end
  end

  // bus engine: edges of the serial clock step the transfer
  always_comb
  begin
    sclRise = sclSync2_r & ~sclPrev_r;
    sclFall = ~sclSync2_r & sclPrev_r;
    startSeen = sclSync2_r & sclPrev_r & sdaPrev_r & ~sdaSync2_r;
    stopSeen = sclSync2_r & sclPrev_r & ~sdaPrev_r & sdaSync2_r;
    match = (shift_r[7:1] == DEV_ID_PAGE) || (shift_r[7:1] == DEV_DIAG_PAGE);
    st_nxt = st_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    diagPage_nxt = diagPage_r;
    rdMode_nxt = rdMode_r;
    devAck_nxt = devAck_r;
    hostAck_nxt = hostAck_r;
    wrPend_nxt = wrPend_r;
    wrData_nxt = wrData_r;
    reqTog_nxt = reqTog_r;
    sdaOe_nxt = sdaOe_r;
    rdByte = readByte(diagPage_r, ptr_r, linkSync2_r.status);
    if (startSeen)
    begin
      st_nxt = S_DEVADDR;
      bitCnt_nxt = '0;
      sdaOe_nxt = 1'b0;
    end
    else if (stopSeen)
    begin
      st_nxt = S_IDLE;
      sdaOe_nxt = 1'b0;
      if (wrPend_r)
      begin
        // stop condition starts the internal write
        reqTog_nxt = ~reqTog_r;
        wrPend_nxt = 1'b0;
      end
    end
    else
    begin
      unique case (st_r)
        S_IDLE:
        begin
          sdaOe_nxt = 1'b0;
        end
        S_DEVADDR, S_WORD, S_WRDATA:
        begin
          if (sclRise)
          begin
            shift_nxt = {shift_r[6:0], sdaSync2_r};
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
          else if (sclFall && bitCnt_r == BITS_PER_BYTE)
          begin
            bitCnt_nxt = '0;
            if (st_r == S_DEVADDR)
            begin
              devAck_nxt = match && linkSync2_r.ready && !linkSync2_r.busy;
              diagPage_nxt = (shift_r[7:1] == DEV_DIAG_PAGE);
              rdMode_nxt = shift_r[0];
              sdaOe_nxt = devAck_nxt;
              st_nxt = S_ACKDEV;
            end
            else if (st_r == S_WORD)
            begin
              ptr_nxt = shift_r;
              sdaOe_nxt = 1'b1;
              st_nxt = S_ACKWORD;
            end
            else
            begin
              if (isCtrlByte(diagPage_r, ptr_r))
              begin
                wrData_nxt = shift_r;
                wrPend_nxt = 1'b1;
              end
              ptr_nxt = ptr_r + 8'h01;
              sdaOe_nxt = 1'b1;
              st_nxt = S_ACKDATA;
            end
          end
        end
        S_ACKDEV:
        begin
          if (sclFall)
          begin
            if (!devAck_r)
            begin
              sdaOe_nxt = 1'b0;
              st_nxt = S_IDLE;
            end
            else if (rdMode_r)
            begin
              shift_nxt = rdByte;
              sdaOe_nxt = ~rdByte[7];
              st_nxt = S_RDDATA;
            end
            else
            begin
              sdaOe_nxt = 1'b0;
              st_nxt = S_WORD;
            end
          end
        end
        S_ACKWORD, S_ACKDATA:
        begin
          if (sclFall)
          begin
            sdaOe_nxt = 1'b0;
            st_nxt = S_WRDATA;
          end
        end
        S_RDDATA:
        begin
          if (sclRise)
            bitCnt_nxt = bitCnt_r + 4'h1;
          else if (sclFall)
          begin
            if (bitCnt_r == BITS_PER_BYTE)
            begin
              bitCnt_nxt = '0;
              sdaOe_nxt = 1'b0;
              st_nxt = S_RDACK;
            end
            else
            begin
              sdaOe_nxt = ~shift_r[6];
              shift_nxt = {shift_r[6:0], 1'b0};
            end
          end
        end
        S_RDACK:
        begin
          if (sclRise)
            hostAck_nxt = ~sdaSync2_r;
          else if (sclFall)
          begin
            if (hostAck_r)
            begin
              ptr_nxt = ptr_r + 8'h01;
              shift_nxt = readByte(diagPage_r, ptr_nxt, linkSync2_r.status);
              sdaOe_nxt = ~shift_nxt[7];
              st_nxt = S_RDDATA;
            end
            else
            begin
              st_nxt = S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // registers of the link domain
  always_ff @(posedge linkClk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= S_IDLE;
      bitCnt_r <= '0;
      shift_r <= '0;
      ptr_r <= '0;
      diagPage_r <= 1'b0;
      rdMode_r <= 1'b0;
      devAck_r <= 1'b0;
      hostAck_r <= 1'b0;
      wrPend_r <= 1'b0;
      wrData_r <= '0;
      reqTog_r <= 1'b0;
      sdaOe_r <= 1'b0;
      sdaOut_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      diagPage_r <= diagPage_nxt;
      rdMode_r <= rdMode_nxt;
      devAck_r <= devAck_nxt;
      hostAck_r <= hostAck_nxt;
      wrPend_r <= wrPend_nxt;
      wrData_r <= wrData_nxt;
      reqTog_r <= reqTog_nxt;
      sdaOe_r <= sdaOe_nxt;
      sdaOut_r <= 1'b0; // open drain: only ever pulls low
    end
  end

  assign sdaOe = sdaOe_r;
  assign sdaOut = sdaOut_r;

endmodule

`default_nettype wire

//--- sfp_ctrl_sva.sv
/*
  Concurrent checks on the ports of the control and status block.
  Assumes it is bound to the top module from the testbench top file.
*/
`timescale 1ns/1ns
`default_nettype none

module sfp_ctrl_sva
  import sfp_ctrl_pkg::*;
#(
  parameter int INIT_CYCLES = 50,
  parameter int SERIAL_CYCLES = 40
)
(
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset
  input wire logic txOffPin, // hardware disable
  input wire logic rateSelPin, // hardware rate
  input wire logic sigLostIn, // detector level
  input wire logic laserFaultIn, // driver fault
  input wire logic sdaOe, // module pulls data low
  input wire logic laserEnable, // optical output on
  input wire logic txFaultPin, // latched fault
  input wire logic receiveSignalLost, // signal-lost pin
  input wire logic rxRateHigh, // receiver rate
  input wire logic transmitSupplyRailSel // monitor select
);
  int lowCnt_r;
  int lowCnt_nxt;
  int offCnt_r;
  int offCnt_nxt;
  int upCnt_r;
  int upCnt_nxt;

  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  always_comb
  begin
    lowCnt_nxt = laserEnable ? 0 : lowCnt_r + 1;
    offCnt_nxt = txOffPin ? offCnt_r + 1 : 0;
    upCnt_nxt = (upCnt_r < SERIAL_CYCLES) ? upCnt_r + 1 : upCnt_r;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lowCnt_r <= 0;
      offCnt_r <= 0;
      upCnt_r <= 0;
    end
    else
    begin
      lowCnt_r <= lowCnt_nxt;
      offCnt_r <= offCnt_nxt;
      upCnt_r <= upCnt_nxt;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_OFF_EDGE: assert property ($rose(txOffPin) |-> ##[1:6] !laserEnable)
    else $error("laser on after disable edge");
  AST_OFF_HOLD: assert property (txOffPin [*8] |-> !laserEnable)
    else $error("laser on while disabled");
  AST_INIT_WAIT: assert property ($rose(laserEnable) |-> lowCnt_r >= INIT_CYCLES)
    else $error("laser on before init time");
  AST_LOST_SET: assert property (sigLostIn [*6] |-> receiveSignalLost)
    else $error("signal-lost pin not set");
  AST_LOST_CLR: assert property (!sigLostIn [*6] |-> !receiveSignalLost)
    else $error("signal-lost pin not cleared");
  AST_RATE_PIN: assert property (rateSelPin [*6] |-> rxRateHigh)
    else $error("rate pin not followed");
  AST_FAULT_CLR: assert property ($fell(txFaultPin) |-> offCnt_r >= RESET_CYC)
    else $error("fault cleared by short disable");
  AST_FAULT_SET: assert property ((laserEnable && laserFaultIn) [*2] |-> ##[1:6] txFaultPin)
    else $error("fault not latched");
  AST_FAULT_DARK: assert property (txFaultPin [*2] |-> !laserEnable)
    else $error("laser on during fault");
  AST_RAIL: assert property (transmitSupplyRailSel == RAIL_TX)
    else $error("monitor not on transmit rail");
  AST_BUS_READY: assert property (upCnt_r < SERIAL_CYCLES |-> !sdaOe)
    else $error("bus answered before ready");

  COV_LASER_ON: cover property ($rose(laserEnable));
  COV_FAULT_CLR: cover property ($fell(txFaultPin));
  COV_ACK: cover property ($rose(sdaOe));
endmodule

`default_nettype wire

//--- sfp_host_model.sv
/*
  Host board controller on the two-wire serial bus, as bus master.
  Assumes an open-drain data line with pull-up resolved by the bench.
*/
`timescale 1ns/1ns
`default_nettype none

module sfp_host_model
(
  input wire logic sys_clk, // pacing clock
  input wire logic sdaWire, // resolved data line
  output logic sclPin, // serial clock drive
  output logic sdaLow // pulls data low
);
  initial
  begin
    sclPin = 1'b1;
    sdaLow = 1'b0;
  end

  // quarter bit: 25 cycles, 100 kHz bit rate
  task automatic q;
    repeat (25) @(posedge sys_clk);
  endtask

  // start or repeated start
  task automatic bus_start;
    sdaLow <= 1'b0;
    q();
    sclPin <= 1'b1;
    q();
    sdaLow <= 1'b1;
    q();
    sclPin <= 1'b0;
    q();
  endtask

  task automatic bus_stop;
    sdaLow <= 1'b1;
    q();
    sclPin <= 1'b1;
    q();
    sdaLow <= 1'b0;
    q();
  endtask

  // one bit: data set while clock low, sampled mid-high
  task automatic bitx(input logic b, output logic r);
    sdaLow <= !b;
    q();
    sclPin <= 1'b1;
    q();
    r = sdaWire;
    q();
    sclPin <= 1'b0;
    q();
  endtask

  // eight bits msb first plus acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic hostBit, output logic [7:0] rx,
    output logic devAck);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(tx[i], rx[i]);
    end
    bitx(hostBit, r);
    devAck = !r;
  endtask
endmodule

`default_nettype wire

//--- tb_sfp_module_control_status.sv
/*
  Self-checking bench: pins, soft control byte, fault and power-on.
  Assumes the host model and the checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_sfp_module_control_status import sfp_ctrl_pkg::*;;
  localparam int WRITE_N = 2000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic linkClk = 1'b0;
  logic txOffPin = 1'b0;
  logic rateSelPin = 1'b0;
  logic sigLostIn = 1'b0;
  logic laserFaultIn = 1'b0;
  logic sclPin, sdaLow, sdaOut, sdaOe, laserEnable, txFaultPin;
  logic receiveSignalLost, rxRateHigh, railSel, sdaWire;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;

  // open-drain data line with pull-up
  assign sdaWire = ~(sdaOe | sdaLow);
  always #50 sys_clk = ~sys_clk;
  always
  begin
    #62 linkClk = ~linkClk;
    #63 linkClk = ~linkClk;
  end

  sfp_module_control_status #(.INIT_CYCLES(50), .DATA_CYCLES(3000), .SERIAL_CYCLES(2000),
    .WRITE_CYCLES(WRITE_N)) u_sfp_module_control_status (.sys_clk(sys_clk), .rst(rst),
    .linkClk(linkClk), .txOffPin(txOffPin), .rateSelPin(rateSelPin), .sigLostIn(sigLostIn),
    .laserFaultIn(laserFaultIn), .sclPin(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .laserEnable(laserEnable), .txFaultPin(txFaultPin),
    .receiveSignalLost(receiveSignalLost), .rxRateHigh(rxRateHigh),
    .transmitSupplyRailSel(railSel));
  sfp_host_model u_sfp_host_model (.sys_clk(sys_clk), .sdaWire(sdaWire), .sclPin(sclPin),
    .sdaLow(sdaLow));

  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic s;
    @(negedge sys_clk);
  endtask
  task automatic chk1(input string name, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %b seen %b", name, e, g);
    end
  endtask
  task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // bus transactions
  // ---------------------------------------------------------------
  task automatic put(input logic [7:0] b, input logic e);
    logic [7:0] rx;
    logic a;
    u_sfp_host_model.xfer(b, 1'b1, rx, a);
    chk1("ack", e, a);
  endtask
  task automatic rd_ctl(output logic [7:0] v);
    logic a;
    u_sfp_host_model.bus_start();
    put(8'hA2, 1'b1);
    put(8'h6E, 1'b1);
    u_sfp_host_model.bus_start();
    put(8'hA3, 1'b1);
    u_sfp_host_model.xfer(8'hFF, 1'b1, v, a);
    u_sfp_host_model.bus_stop();
  endtask
  task automatic wr_ctl(input logic [7:0] v);
    u_sfp_host_model.bus_start();
    put(8'hA2, 1'b1);
    put(8'h6E, 1'b1);
    put(v, 1'b1);
    u_sfp_host_model.bus_stop();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_power;
    w(10);
    s();
    chk1("laserEnable", 1'b0, laserEnable);
    chk1("railSel", 1'b1, railSel);
    chk1("sdaOut", 1'b0, sdaOut);
    w(50);
    s();
    chk1("laserEnable", 1'b1, laserEnable);
    w(1);
    u_sfp_host_model.bus_start();
    put(8'hA2, 1'b0);
    u_sfp_host_model.bus_stop();
    w(1000);
  endtask
  task automatic t_pins;
    txOffPin <= 1'b1;
    w(10);
    s();
    chk1("laserEnable", 1'b0, laserEnable);
    w(1);
    txOffPin <= 1'b0;
    w(10);
    s();
    chk1("laserEnable", 1'b0, laserEnable);
    w(60);
    s();
    chk1("laserEnable", 1'b1, laserEnable);
    for (int i = 0; i < 2; i++)
    begin
      w(1);
      rateSelPin <= ~i[0];
      sigLostIn <= ~i[0];
      w(10);
      s();
      chk1("rxRateHigh", ~i[0], rxRateHigh);
      chk1("receiveSignalLost", ~i[0], receiveSignalLost);
    end
  endtask
  task automatic t_soft;
    logic [7:0] v;
    w(1);
    u_sfp_host_model.bus_start();
    put(8'hC0, 1'b0);
    u_sfp_host_model.bus_stop();
    sigLostIn <= 1'b1;
    wr_ctl(8'hFF);
    w(20);
    s();
    chk1("laserEnable", 1'b0, laserEnable);
    chk1("rxRateHigh", 1'b1, rxRateHigh);
    w(1);
    u_sfp_host_model.bus_start();
    put(8'hA2, 1'b0);
    u_sfp_host_model.bus_stop();
    w(WRITE_N);
    rd_ctl(v);
    chk8("control_status_byte", 8'h4B, v);
    sigLostIn <= 1'b0;
    wr_ctl(8'h00);
    w(20);
    s();
    chk1("rxRateHigh", 1'b0, rxRateHigh);
    w(60);
    s();
    chk1("laserEnable", 1'b1, laserEnable);
  endtask
  task automatic t_fault;
    logic [7:0] v;
    w(1);
    laserFaultIn <= 1'b1;
    w(10);
    s();
    chk1("txFaultPin", 1'b1, txFaultPin);
    chk1("laserEnable", 1'b0, laserEnable);
    w(1);
    laserFaultIn <= 1'b0;
    w(WRITE_N);
    rd_ctl(v);
    chk8("control_status_byte", 8'h05, v);
    txOffPin <= 1'b1;
    w(50);
    txOffPin <= 1'b0;
    w(10);
    s();
    chk1("txFaultPin", 1'b1, txFaultPin);
    w(1);
    txOffPin <= 1'b1;
    w(110);
    s();
    chk1("txFaultPin", 1'b0, txFaultPin);
    w(1);
    txOffPin <= 1'b0;
    w(60);
    s();
    chk1("laserEnable", 1'b1, laserEnable);
  endtask

  // cycle ceiling against a hang
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      fails = fails + 1;
      close_out();
    end
  end

  // main sequence
  initial
  begin
    w(12);
    rst <= 1'b0;
    t_power();
    t_pins();
    t_soft();
    t_fault();
    close_out();
  end
endmodule

bind sfp_module_control_status sfp_ctrl_sva #(.INIT_CYCLES(INIT_CYCLES),
  .SERIAL_CYCLES(SERIAL_CYCLES)) u_sfp_ctrl_sva (.sys_clk(sys_clk), .rst(rst),
  .txOffPin(txOffPin), .rateSelPin(rateSelPin), .sigLostIn(sigLostIn),
  .laserFaultIn(laserFaultIn), .sdaOe(sdaOe), .laserEnable(laserEnable),
  .txFaultPin(txFaultPin), .receiveSignalLost(receiveSignalLost), .rxRateHigh(rxRateHigh),
  .transmitSupplyRailSel(transmitSupplyRailSel));

`default_nettype wire
